// *** uart_fc_pkg.sv ***
// Register map, field positions, reset values and state types of the serial port
package uart_fc_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam int SCALER_W = 12;
    localparam int CHAR_BITS = 8;
    localparam int TICKS_PER_BIT = 8;
    localparam int HALF_BIT_TICKS = 4;
    localparam int FILTER_LEN = 8;

    localparam logic [ADDR_W-1:0] CONTROL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] SCALER_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] DATA_OFS = 4'hC;

    // Control fields
    localparam int CTL_RECEIVE_ENABLE = 0;
    localparam int CTL_TRANSMIT_ENABLE = 1;
    localparam int CTL_RECEIVE_IRQ_ENABLE = 2;
    localparam int CTL_TRANSMIT_IRQ_ENABLE = 3;
    localparam int CTL_PARITY_SELECT = 4;
    localparam int CTL_PARITY_ENABLE = 5;
    localparam int CTL_FLOW_CONTROL_ENABLE = 6;
    localparam int CTL_LOOPBACK_ENABLE = 7;
    localparam int CTL_TICK_SOURCE_SELECT = 8;
    localparam int CTL_W = 9;

    // Status fields
    localparam int STS_DATA_READY = 0;
    localparam int STS_SHIFT_EMPTY = 1;
    localparam int STS_HOLD_EMPTY = 2;
    localparam int STS_BREAK = 3;
    localparam int STS_OVERRUN = 4;
    localparam int STS_PARITY_ERROR = 5;
    localparam int STS_FRAMING_ERROR = 6;

    localparam logic [CTL_W-1:0] CONTROL_RST = 9'h000;
    localparam logic [SCALER_W-1:0] SCALER_RST = 12'h000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } rx_state_t;
endpackage

// *** uart_with_flow_control.sv ***
// Serial port with flow control, noise filter and AXI4-Lite register slave
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
module uart_with_flow_control #(
    parameter int SCALER_W = uart_fc_pkg::SCALER_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [uart_fc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [uart_fc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [uart_fc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [uart_fc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    input wire logic cts_i,
    output logic rts_o,
    input wire logic ext_tick_i,
    output logic tx_irq_o,
    output logic rx_irq_o
);
    localparam int CB = uart_fc_pkg::CHAR_BITS;

    logic [uart_fc_pkg::CTL_W-1:0] port_control_reg;
    logic [SCALER_W-1:0] scaler_reload_value;
    logic [SCALER_W-1:0] scaler_count;
    logic tick;
    logic ext_tick_prev;
    logic [uart_fc_pkg::ADDR_W-1:0] wr_addr;
    logic [uart_fc_pkg::DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic data_read;

    logic receive_enable, transmit_enable, parity_select, parity_enable;
    logic flow_control_enable, loopback_enable, tick_source_select;
    assign receive_enable = port_control_reg[uart_fc_pkg::CTL_RECEIVE_ENABLE];
    assign transmit_enable = port_control_reg[uart_fc_pkg::CTL_TRANSMIT_ENABLE];
    assign parity_select = port_control_reg[uart_fc_pkg::CTL_PARITY_SELECT];
    assign parity_enable = port_control_reg[uart_fc_pkg::CTL_PARITY_ENABLE];
    assign flow_control_enable = port_control_reg[uart_fc_pkg::CTL_FLOW_CONTROL_ENABLE];
    assign loopback_enable = port_control_reg[uart_fc_pkg::CTL_LOOPBACK_ENABLE];
    assign tick_source_select = port_control_reg[uart_fc_pkg::CTL_TICK_SOURCE_SELECT];

    // Transmit side
    logic [CB-1:0] tx_hold;
    logic tx_hold_full;
    logic [CB-1:0] tx_shift;
    uart_fc_pkg::tx_state_t tx_state;
    logic [2:0] tx_tick_cnt;
    logic [2:0] tx_bit_cnt;
    logic tx_line;
    logic tx_load;
    logic cts_eff;

    // Receive side
    logic [uart_fc_pkg::FILTER_LEN-1:0] filter_sr;
    logic rx_filtered;
    logic rx_prev;
    logic rx_line;
    uart_fc_pkg::rx_state_t rx_state;
    logic [2:0] rx_tick_cnt;
    logic [2:0] rx_bit_cnt;
    logic [CB-1:0] rx_shift;
    logic rx_par_bit;
    logic [CB-1:0] rx_hold;
    logic data_ready_flag, break_flag, overrun_flag, parity_error_flag, framing_error_flag;
    logic rx_done;
    logic rx_clean;
    logic set_pe, set_fe, set_br, set_ov;
    logic rts_int;

    // ---------------- AXI4-Lite slave ----------------
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign data_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == uart_fc_pkg::DATA_OFS;

    // Address and data are latched independently, so either order works
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= uart_fc_pkg::RESP_OKAY;
            wr_addr <= '0;
            wr_data <= uart_fc_pkg::ZERO_WORD;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr[1:0] == 2'h0) ? uart_fc_pkg::RESP_OKAY
                                                      : uart_fc_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= uart_fc_pkg::ZERO_WORD;
            s_axi_rresp <= uart_fc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= uart_fc_pkg::RESP_OKAY;
                s_axi_rdata <= uart_fc_pkg::ZERO_WORD;
                case (s_axi_araddr)
                    uart_fc_pkg::CONTROL_OFS: begin
                        s_axi_rdata[uart_fc_pkg::CTL_W-1:0] <= port_control_reg;
                    end
                    uart_fc_pkg::STATUS_OFS: begin
                        s_axi_rdata[uart_fc_pkg::STS_DATA_READY] <= data_ready_flag;
                        s_axi_rdata[uart_fc_pkg::STS_SHIFT_EMPTY] <= tx_state == uart_fc_pkg::TX_IDLE;
                        s_axi_rdata[uart_fc_pkg::STS_HOLD_EMPTY] <= !tx_hold_full;
                        s_axi_rdata[uart_fc_pkg::STS_BREAK] <= break_flag;
                        s_axi_rdata[uart_fc_pkg::STS_OVERRUN] <= overrun_flag;
                        s_axi_rdata[uart_fc_pkg::STS_PARITY_ERROR] <= parity_error_flag;
                        s_axi_rdata[uart_fc_pkg::STS_FRAMING_ERROR] <= framing_error_flag;
                    end
                    uart_fc_pkg::SCALER_OFS: begin
                        s_axi_rdata[SCALER_W-1:0] <= scaler_reload_value;
                    end
                    uart_fc_pkg::DATA_OFS: begin
                        s_axi_rdata[CB-1:0] <= rx_hold;
                    end
                    default: begin
                        s_axi_rresp <= uart_fc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Control and scaler registers honour byte lane strobes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_control_reg <= uart_fc_pkg::CONTROL_RST;
            scaler_reload_value <= uart_fc_pkg::SCALER_RST;
        end else if (do_write) begin
            if (wr_addr == uart_fc_pkg::CONTROL_OFS) begin
                if (wr_strb[0]) begin
                    port_control_reg[7:0] <= wr_data[7:0];
                end
                if (wr_strb[1]) begin
                    port_control_reg[8] <= wr_data[8];
                end
            end
            if (wr_addr == uart_fc_pkg::SCALER_OFS) begin
                if (wr_strb[0]) begin
                    scaler_reload_value[7:0] <= wr_data[7:0];
                end
                if (wr_strb[1]) begin
                    scaler_reload_value[SCALER_W-1:8] <= wr_data[SCALER_W-1:8];
                end
            end
        end
    end

    // ---------------- Bit tick ----------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scaler_count <= uart_fc_pkg::SCALER_RST;
            ext_tick_prev <= 1'b0;
            tick <= 1'b0;
        end else begin
            ext_tick_prev <= ext_tick_i;
            tick <= 1'b0;
            if (tick_source_select) begin
                // Edge detect relies on phases of at least one clock
                tick <= ext_tick_i && !ext_tick_prev;
                scaler_count <= scaler_reload_value;
            end else if (transmit_enable || receive_enable) begin
                if (scaler_count == '0) begin
                    scaler_count <= scaler_reload_value;
                    tick <= 1'b1;
                end else begin
                    scaler_count <= scaler_count - 1'b1;
                end
            end else begin
                scaler_count <= scaler_reload_value;
            end
        end
    end

    // ---------------- Transmitter ----------------
    assign cts_eff = loopback_enable ? rts_int : cts_i;
    assign tx_load = tick && tx_state == uart_fc_pkg::TX_IDLE && transmit_enable && tx_hold_full
                     && (!flow_control_enable || cts_eff);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_hold <= '0;
            tx_hold_full <= 1'b0;
        end else begin
            if (tx_load) begin
                tx_hold_full <= 1'b0;
            end
            // A new byte overwrites an unsent one; software checks hold-empty first
            if (do_write && wr_addr == uart_fc_pkg::DATA_OFS && wr_strb[0]) begin
                tx_hold <= wr_data[CB-1:0];
                tx_hold_full <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_state <= uart_fc_pkg::TX_IDLE;
            tx_shift <= '0;
            tx_tick_cnt <= 3'h0;
            tx_bit_cnt <= 3'h0;
            tx_line <= 1'b1;
        end else begin
            case (tx_state)
                uart_fc_pkg::TX_IDLE: begin
                    tx_line <= 1'b1;
                    if (tx_load) begin
                        tx_shift <= tx_hold;
                        tx_line <= 1'b0;
                        tx_tick_cnt <= 3'h0;
                        tx_state <= uart_fc_pkg::TX_START;
                    end
                end
                default: begin
                    // Each bit lasts eight ticks; flow control no longer checked
                    if (tick) begin
                        tx_tick_cnt <= tx_tick_cnt + 1'b1;
                        if (tx_tick_cnt == 3'(uart_fc_pkg::TICKS_PER_BIT - 1)) begin
                            case (tx_state)
                                uart_fc_pkg::TX_START: begin
                                    tx_line <= tx_shift[0];
                                    tx_bit_cnt <= 3'h0;
                                    tx_state <= uart_fc_pkg::TX_DATA;
                                end
                                uart_fc_pkg::TX_DATA: begin
                                    if (tx_bit_cnt == 3'(CB - 1)) begin
                                        if (parity_enable) begin
                                            tx_line <= (^tx_shift) ^ !parity_select;
                                            tx_state <= uart_fc_pkg::TX_PARITY;
                                        end else begin
                                            tx_line <= 1'b1;
                                            tx_state <= uart_fc_pkg::TX_STOP;
                                        end
                                    end else begin
                                        tx_line <= tx_shift[tx_bit_cnt + 3'h1];
                                        tx_bit_cnt <= tx_bit_cnt + 1'b1;
                                    end
                                end
                                uart_fc_pkg::TX_PARITY: begin
                                    tx_line <= 1'b1;
                                    tx_state <= uart_fc_pkg::TX_STOP;
                                end
                                default: begin
                                    tx_line <= 1'b1;
                                    tx_state <= uart_fc_pkg::TX_IDLE;
                                end
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    // ---------------- Receiver ----------------
    assign rx_line = loopback_enable ? tx_line : serial_in_pin_i;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filter_sr <= '1;
            rx_filtered <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            filter_sr <= {filter_sr[uart_fc_pkg::FILTER_LEN-2:0], rx_line};
            if (&filter_sr) begin
                rx_filtered <= 1'b1;
            end else if (~|filter_sr) begin
                rx_filtered <= 1'b0;
            end
            rx_prev <= rx_filtered;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_state <= uart_fc_pkg::RX_IDLE;
            rx_tick_cnt <= 3'h0;
            rx_bit_cnt <= 3'h0;
            rx_shift <= '0;
            rx_par_bit <= 1'b0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!receive_enable) begin
                rx_state <= uart_fc_pkg::RX_IDLE;
            end else begin
                case (rx_state)
                    uart_fc_pkg::RX_IDLE: begin
                        if (rx_prev && !rx_filtered) begin
                            rx_tick_cnt <= 3'h0;
                            rx_state <= uart_fc_pkg::RX_START;
                        end
                    end
                    uart_fc_pkg::RX_START: begin
                        if (tick) begin
                            rx_tick_cnt <= rx_tick_cnt + 1'b1;
                            if (rx_tick_cnt == 3'(uart_fc_pkg::HALF_BIT_TICKS - 1)) begin
                                rx_tick_cnt <= 3'h0;
                                rx_bit_cnt <= 3'h0;
                                // Still low at half-bit: a real start bit
                                rx_state <= rx_filtered ? uart_fc_pkg::RX_IDLE
                                                        : uart_fc_pkg::RX_DATA;
                            end
                        end
                    end
                    default: begin
                        if (tick) begin
                            rx_tick_cnt <= rx_tick_cnt + 1'b1;
                            if (rx_tick_cnt == 3'(uart_fc_pkg::TICKS_PER_BIT - 1)) begin
                                case (rx_state)
                                    uart_fc_pkg::RX_DATA: begin
                                        rx_shift <= {rx_filtered, rx_shift[CB-1:1]};
                                        rx_bit_cnt <= rx_bit_cnt + 1'b1;
                                        if (rx_bit_cnt == 3'(CB - 1)) begin
                                            rx_state <= parity_enable ? uart_fc_pkg::RX_PARITY
                                                                      : uart_fc_pkg::RX_STOP;
                                        end
                                    end
                                    uart_fc_pkg::RX_PARITY: begin
                                        rx_par_bit <= rx_filtered;
                                        rx_state <= uart_fc_pkg::RX_STOP;
                                    end
                                    default: begin
                                        rx_done <= 1'b1;
                                        rx_par_bit <= rx_par_bit;
                                        rx_state <= uart_fc_pkg::RX_IDLE;
                                    end
                                endcase
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Stop bit is the filtered line at the completion cycle
    logic stop_bit;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stop_bit <= 1'b1;
        end else if (rx_state == uart_fc_pkg::RX_STOP && tick) begin
            stop_bit <= rx_filtered;
        end
    end

    assign set_pe = rx_done && parity_enable && ((^{rx_shift, rx_par_bit}) ^ !parity_select);
    assign set_fe = rx_done && !stop_bit;
    assign set_br = rx_done && !stop_bit && rx_shift == '0;
    assign set_ov = rx_done && data_ready_flag;
    assign rx_clean = rx_done && !set_pe && !set_fe && !set_ov;

    // Old unread byte is kept on overrun; the newer one is lost
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_hold <= '0;
            data_ready_flag <= 1'b0;
        end else begin
            if (data_read) begin
                data_ready_flag <= 1'b0;
            end
            if (rx_clean) begin
                rx_hold <= rx_shift;
                data_ready_flag <= 1'b1;
            end
        end
    end

    // Write 1 clears an error flag; a new error in the same cycle wins
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            break_flag <= 1'b0;
            overrun_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
        end else begin
            if (do_write && wr_addr == uart_fc_pkg::STATUS_OFS && wr_strb[0]) begin
                if (wr_data[uart_fc_pkg::STS_BREAK]) break_flag <= 1'b0;
                if (wr_data[uart_fc_pkg::STS_OVERRUN]) overrun_flag <= 1'b0;
                if (wr_data[uart_fc_pkg::STS_PARITY_ERROR]) parity_error_flag <= 1'b0;
                if (wr_data[uart_fc_pkg::STS_FRAMING_ERROR]) framing_error_flag <= 1'b0;
            end
            if (set_br) break_flag <= 1'b1;
            if (set_ov) overrun_flag <= 1'b1;
            if (set_pe) parity_error_flag <= 1'b1;
            if (set_fe) framing_error_flag <= 1'b1;
        end
    end

    // ---------------- Pins and interrupt requests ----------------
    assign rts_int = receive_enable && !data_ready_flag;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            serial_out_pin_o <= 1'b1;
            rts_o <= 1'b0;
            tx_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;
        end else begin
            serial_out_pin_o <= loopback_enable ? 1'b1 : tx_line;
            if (loopback_enable) begin
                rts_o <= flow_control_enable;
            end else begin
                rts_o <= flow_control_enable && rts_int;
            end
            tx_irq_o <= tx_load && port_control_reg[uart_fc_pkg::CTL_TRANSMIT_IRQ_ENABLE];
            rx_irq_o <= rx_done && port_control_reg[uart_fc_pkg::CTL_RECEIVE_IRQ_ENABLE];
        end
    end
endmodule // uart_with_flow_control

// *** uart_fc_assertions.sv ***
// Bus handshake, serial bit timing and interrupt pulse checks of the serial port
module uart_fc_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic serial_out_pin_o, tx_irq_o, rx_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // A bit is 8 ticks and a tick is at least one clock
    AST_TX_LOW: assert property ($fell(serial_out_pin_o) |-> !serial_out_pin_o [*8])
        else $error("low bit too short");
    AST_TX_HIGH: assert property ($rose(serial_out_pin_o) |-> serial_out_pin_o [*8])
        else $error("high bit too short");
    AST_TX_IRQ: assert property (tx_irq_o |=> !tx_irq_o)
        else $error("transmit request not a pulse");
    AST_RX_IRQ: assert property (rx_irq_o |=> !rx_irq_o)
        else $error("receive request not a pulse");
    AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    cover property (tx_irq_o);
    cover property (rx_irq_o);
    cover property ($fell(serial_out_pin_o));
endmodule // uart_fc_assertions

bind uart_with_flow_control uart_fc_assertions i_chk (.*);

// *** uart_fc_peer.sv ***
// Remote serial device: sends frames on the receive line, grants clear-to-send
module uart_fc_peer #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clk_i,
    input wire logic rx_i,
    output logic line_o,
    output logic cts_o
);
    initial begin
        line_o = 1;
        cts_o = 1;
    end
    // Stop level is a choice so that broken frames can be sent
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        line_o <= 1;
    endtask
    task automatic grant(input logic g);
        cts_o <= g;
    endtask
    // Samples the device's frame at bit centres, start edge as reference
    task automatic recv(output logic [7:0] d);
        @(negedge rx_i);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            d[i] = rx_i;
        end
    endtask
endmodule // uart_fc_peer

// *** tb.sv ***
// Self-checking bench: loop-back table, error frames, bus refusal
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, sys_rst_i = 1, ext_tick_i = 0, serial_in_pin_i, cts_i;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, serial_out_pin_o, rts_o, tx_irq_o, rx_irq_o;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, st;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int fail_count = 0, tests_run = 0, cyc = 0, irqs = 0;
    // Control byte, data byte
    logic [15:0] rows [4] = '{16'h8FA5, 16'hBF3C, 16'hAF01, 16'hCFFE};
    initial forever #10 clk_i = ~clk_i;
    uart_with_flow_control i_dut (.*);
    uart_fc_peer i_peer (.clk_i, .rx_i(serial_out_pin_o), .line_o(serial_in_pin_i), .cts_o(cts_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        st = s_axi_rdata;
        s_axi_rready <= 0;
    endtask
    task automatic conclude();
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Polling loops rely on this ceiling alone
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        irqs <= irqs + tx_irq_o + rx_irq_o;
        // Four clocks a phase: well above one clock, eight ticks a bit
        if (cyc % 4 == 0) ext_tick_i <= !ext_tick_i;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 0;
        rd(4'h4);
        check(st[1], 1);
        wr(4'h1, 0);
        check(r, 2'h2);
        wr(4'h8, 3);
        foreach (rows[i]) begin
            wr(4'h0, rows[i][15:8]);
            wr(4'hC, rows[i][7:0]);
            check(serial_out_pin_o, 1);
            check(rts_o, rows[i][14]);
            do rd(4'h4); while (!st[0]);
            check(st & 32'h79, 1);
            rd(4'hC);
            check(st, rows[i][7:0]);
            rd(4'h4);
            check(st[0], 0);
            $display("loop-back row %0d done", i);
        end
        check(irqs, 8);
        wr(4'h0, 32'h41);
        check(rts_o, 1);
        i_peer.send(8'h55, 0);
        do rd(4'h4); while (!st[6]);
        check(st & 32'h79, 32'h40);
        // Filter needs eight quiet clocks before the next edge
        repeat (64) @(posedge clk_i);
        i_peer.send(8'h00, 0);
        do rd(4'h4); while (!st[3]);
        check(st & 32'h79, 32'h48);
        wr(4'h4, 32'h78);
        rd(4'h4);
        check(st & 32'h79, 0);
        $display("error frame tests done");
        wr(4'h0, 32'h61);
        i_peer.send(8'h01, 1);
        do rd(4'h4); while (!st[5]);
        check(st & 32'h79, 32'h20);
        wr(4'h0, 32'h41);
        i_peer.send(8'h3C, 1);
        do rd(4'h4); while (!st[0]);
        check(rts_o, 0);
        i_peer.send(8'h99, 1);
        rd(4'h4);
        check(st & 32'h79, 32'h31);
        rd(4'hC);
        check(st, 32'h3C);
        wr(4'h4, 32'h30);
        i_peer.grant(0);
        wr(4'h0, 32'h43);
        wr(4'hC, 32'hC3);
        repeat (100) @(posedge clk_i);
        check(serial_out_pin_o, 1);
        i_peer.grant(1);
        i_peer.recv(st[7:0]);
        check(st[7:0], 8'hC3);
        repeat (64) @(posedge clk_i);
        rd(4'h4);
        check(st[2:1], 2'h3);
        // A slow scaler would overrun the timeout, so the pin must be used
        wr(4'h8, 32'hFFF);
        wr(4'h0, 32'h18F);
        wr(4'hC, 32'h5A);
        do rd(4'h4); while (!st[0]);
        rd(4'hC);
        check(st, 32'h5A);
        $display("flow control and tick pin tests done");
        conclude();
    end
endmodule // tb
